// ---- rtl/sbtap_port.sv ----
// boundary-scan test port: controller, instruction, bypass, id and pin-ring chains
//
// Functional notes
// - chains sample on tck rise, drive tdo on fall
// - one register in path, by state and instruction
// - three-bit instruction, loaded only in ir path
// - idcode active after power-up and reset state
// - capture-ir loads 01 into low bits
// - shift-ir shifts new in, old out
// - instruction takes effect at update-ir; reset state forces idcode
// - bypass bit one long, cleared under bypass
// - bypass gives single stage in shift-dr
// - pin-ring chain 70 or 51 bits
// - capture-dr loads pins, shift-dr shifts them
// - ring msb from tdi, lsb to tdo
// - idcode captures constant id, shifts it
// - id bit 0 leaves first
// - all-zero code samples and floats outputs
// - sample-z floats outputs and shifts ring
// - sample captures pins into ring
// - update-dr under sample does nothing
// - port only observes, never drives pins
// - five tms-high edges reach reset state
// - id word fields: rev, depth, width, six zeros, maker, one
// - tdo off after power-up reset
`timescale 1ns/10ps
`include "sbtap_defines.svh"

module sbtap_port
    import sbtap_pkg::*;
#(
    parameter int         BSR_LEN  = `SBTAP_BSR_LEN_X36,
    parameter logic [3:0] REVISION = 4'h0,    // arbitrary value
    parameter logic [10:0] MAKER   = 11'h2aa  // arbitrary value
) (
    // system clock side
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ce,
    // pin ring to observe, system-clock domain
    input  wire logic [BSR_LEN-1:0] i_pin_ring,
    // test link, on its own clock
    input  wire logic               i_tck,
    input  wire sbtap_link_in_type  i_link,
    output logic                    o_tdo,
    output logic                    o_tdo_oe_n,
    // float request toward the data output buffers, system domain
    output logic                    o_float_outputs
);

    initial begin
        if (BSR_LEN != `SBTAP_BSR_LEN_X36 && BSR_LEN != `SBTAP_BSR_LEN_X18)
            $error("sbtap_port: BSR_LEN must be 70 or 51");
    end

    localparam logic [31:0] ID_WORD = {REVISION, `SBTAP_ID_DEPTH, `SBTAP_ID_WIDTHCODE,
                                       6'h00, MAKER, `SBTAP_ID_PRESENT};

    sbtap_state_type                state;
    sbtap_state_type                next_state;
    logic [`SBTAP_IR_WIDTH-1:0]     ir_shift;
    logic [`SBTAP_IR_WIDTH-1:0]     ir_active;
    logic                           bypass_bit;
    logic [`SBTAP_ID_WIDTH-1:0]     id_shift;
    logic [BSR_LEN-1:0]             ring_shift;
    logic [BSR_LEN-1:0]             ring_meta;
    logic [BSR_LEN-1:0]             ring_sync;
    logic                           float_tck;
    logic                           float_meta;

    wire logic tms = i_link.tms;
    wire logic tdi = i_link.tdi;

    // no test reset pin: the power-up reset is the only asynchronous one
    function automatic sbtap_state_type walk(input sbtap_state_type s, input logic m);
        case (s)
            SBTAP_RESET:     walk = m ? SBTAP_RESET    : SBTAP_IDLE;
            SBTAP_IDLE:      walk = m ? SBTAP_SEL_DR   : SBTAP_IDLE;
            SBTAP_SEL_DR:    walk = m ? SBTAP_SEL_IR   : SBTAP_CAP_DR;
            SBTAP_CAP_DR:    walk = m ? SBTAP_EXIT1_DR : SBTAP_SHIFT_DR;
            SBTAP_SHIFT_DR:  walk = m ? SBTAP_EXIT1_DR : SBTAP_SHIFT_DR;
            SBTAP_EXIT1_DR:  walk = m ? SBTAP_UPDATE_DR : SBTAP_PAUSE_DR;
            SBTAP_PAUSE_DR:  walk = m ? SBTAP_EXIT2_DR : SBTAP_PAUSE_DR;
            SBTAP_EXIT2_DR:  walk = m ? SBTAP_UPDATE_DR : SBTAP_SHIFT_DR;
            SBTAP_UPDATE_DR: walk = m ? SBTAP_SEL_DR   : SBTAP_IDLE;
            SBTAP_SEL_IR:    walk = m ? SBTAP_RESET    : SBTAP_CAP_IR;
            SBTAP_CAP_IR:    walk = m ? SBTAP_EXIT1_IR : SBTAP_SHIFT_IR;
            SBTAP_SHIFT_IR:  walk = m ? SBTAP_EXIT1_IR : SBTAP_SHIFT_IR;
            SBTAP_EXIT1_IR:  walk = m ? SBTAP_UPDATE_IR : SBTAP_PAUSE_IR;
            SBTAP_PAUSE_IR:  walk = m ? SBTAP_EXIT2_IR : SBTAP_PAUSE_IR;
            SBTAP_EXIT2_IR:  walk = m ? SBTAP_UPDATE_IR : SBTAP_SHIFT_IR;
            SBTAP_UPDATE_IR: walk = m ? SBTAP_SEL_DR   : SBTAP_IDLE;
            default:         walk = SBTAP_RESET;
        endcase
    endfunction

    assign next_state = walk(state, tms);

    wire logic op_bypass = (ir_active == `SBTAP_OP_BYPASS);
    wire logic op_idcode = (ir_active == `SBTAP_OP_IDCODE);
    // reserved codes fall back to the bypass bit so tdo always has a source
    wire logic op_ring   = (ir_active == `SBTAP_OP_FLOAT_SMP) ||
                           (ir_active == `SBTAP_OP_SAMPLE_Z)  ||
                           (ir_active == `SBTAP_OP_SAMPLE);
    wire logic op_float  = (ir_active == `SBTAP_OP_FLOAT_SMP) ||
                           (ir_active == `SBTAP_OP_SAMPLE_Z);

    wire logic in_ir_path = (state == SBTAP_SHIFT_IR);
    wire logic in_dr_path = (state == SBTAP_SHIFT_DR);

    // serial source for tdo, one register at a time
    wire logic dr_out = op_idcode ? id_shift[0] :
                        op_ring   ? ring_shift[0] : bypass_bit;
    wire logic next_tdo = in_ir_path ? ir_shift[0] : dr_out;

    // controller state on the rising edge of tck
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SBTAP_RESET;
        end else begin
            state <= next_state;
        end
    end

    // instruction register: capture, shift, update
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_shift <= `SBTAP_OP_IDCODE;
        end else if (state == SBTAP_CAP_IR) begin
            ir_shift <= {ir_shift[2], `SBTAP_CAPTURE_IR_LSB};
        end else if (in_ir_path) begin
            ir_shift <= {tdi, ir_shift[2:1]};
        end
    end

    // update on the falling edge of update-ir, per usual practice
    always_ff @(negedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_active <= `SBTAP_OP_IDCODE;
        end else if (state == SBTAP_RESET) begin
            ir_active <= `SBTAP_OP_IDCODE;
        end else if (state == SBTAP_UPDATE_IR) begin
            ir_active <= ir_shift;
        end
    end

    // data registers on the rising edge of tck
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bypass_bit <= 1'h0;
            id_shift   <= '0;
            ring_shift <= '0;
        end else begin
            if (state == SBTAP_CAP_DR) begin
                bypass_bit <= 1'h0;
                if (op_idcode) begin
                    id_shift <= ID_WORD;
                end
                if (op_ring) begin
                    ring_shift <= ring_sync;
                end
            end else if (in_dr_path) begin
                if (op_idcode) begin
                    id_shift <= {tdi, id_shift[31:1]};
                end else if (op_ring) begin
                    ring_shift <= {tdi, ring_shift[BSR_LEN-1:1]};
                end else begin
                    bypass_bit <= tdi;
                end
            end
            // update-dr drives nothing anywhere; the ring is observe-only
        end
    end

    // pin ring resynchronised onto tck; values in transition are not repeatable
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ring_meta <= '0;
            ring_sync <= '0;
        end else begin
            ring_meta <= i_pin_ring;
            ring_sync <= ring_meta;
        end
    end

    // tdo changes on the falling edge, off outside the shift states
    always_ff @(negedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tdo      <= 1'h0;
            o_tdo_oe_n <= 1'h1;
            float_tck  <= 1'h0;
        end else begin
            o_tdo      <= next_tdo;
            o_tdo_oe_n <= !(in_ir_path || in_dr_path);
            float_tck  <= op_float;
        end
    end

    // float request crosses to the system clock as a level
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            float_meta      <= 1'h0;
            o_float_outputs <= 1'h0;
        end else if (i_ce) begin
            float_meta      <= float_tck;
            o_float_outputs <= float_meta;
        end
    end

endmodule

// ---- pkg/sbtap_defines.svh ----
// timing, field and code constants for the memory boundary-scan test port
`ifndef SBTAP_DEFINES_SVH
`define SBTAP_DEFINES_SVH

`define SBTAP_IR_WIDTH       3
`define SBTAP_ID_WIDTH       32
`define SBTAP_BSR_LEN_X36    70
`define SBTAP_BSR_LEN_X18    51
`define SBTAP_CAPTURE_IR_LSB 2'h1
`define SBTAP_OP_FLOAT_SMP   3'h0
`define SBTAP_OP_IDCODE      3'h1
`define SBTAP_OP_SAMPLE_Z    3'h2
`define SBTAP_OP_SAMPLE      3'h4
`define SBTAP_OP_BYPASS      3'h7
`define SBTAP_RESET_TMS_EDGES 5
`define SBTAP_ID_DEPTH       5'h07
`define SBTAP_ID_WIDTHCODE   5'h03
`define SBTAP_ID_PRESENT     1'h1

`endif

// ---- pkg/sbtap_pkg.sv ----
// types for the memory boundary-scan test port
package sbtap_pkg;

    // gray codes along the usual walk where they fit; all sixteen used
    typedef enum logic [3:0] {
        SBTAP_RESET      = 4'h0,
        SBTAP_IDLE       = 4'h1,
        SBTAP_SEL_DR     = 4'h3,
        SBTAP_CAP_DR     = 4'h2,
        SBTAP_SHIFT_DR   = 4'h6,
        SBTAP_EXIT1_DR   = 4'h7,
        SBTAP_PAUSE_DR   = 4'h5,
        SBTAP_EXIT2_DR   = 4'h4,
        SBTAP_UPDATE_DR  = 4'hc,
        SBTAP_SEL_IR     = 4'hd,
        SBTAP_CAP_IR     = 4'hf,
        SBTAP_SHIFT_IR   = 4'he,
        SBTAP_EXIT1_IR   = 4'ha,
        SBTAP_PAUSE_IR   = 4'hb,
        SBTAP_EXIT2_IR   = 4'h9,
        SBTAP_UPDATE_IR  = 4'h8
    } sbtap_state_type;

    typedef struct packed {
        logic tms;
        logic tdi;
    } sbtap_link_in_type;

endpackage

// ---- testbench/sbtap_chk.sv ----
// concurrent checks on the boundary-scan test port pins
`timescale 1ns/10ps
module sbtap_chk
    import sbtap_pkg::*;
#(
    parameter int BSR_LEN = 70
) (
    // system side
    input wire logic               i_clk,
    input wire logic               i_rst_n,
    input wire logic               i_ce,
    input wire logic [BSR_LEN-1:0] i_pin_ring,
    // test link
    input wire logic               i_tck,
    input wire sbtap_link_in_type  i_link,
    input wire logic               o_tdo,
    input wire logic               o_tdo_oe_n,
    input wire logic               o_float_outputs
);
    logic tdo_at_rise;
    default clocking @(posedge i_tck); endclocking
    default disable iff (!i_rst_n);
    always_ff @(posedge i_tck or negedge i_rst_n) begin
        if (!i_rst_n) tdo_at_rise <= 1'b0;
        else tdo_at_rise <= o_tdo;
    end
    sequence s_rst; i_link.tms [*5]; endsequence
    sequence s_shdr; s_rst ##1 !i_link.tms ##1 i_link.tms ##1 !i_link.tms [*2]; endsequence
    sequence s_shir; s_rst ##1 !i_link.tms ##1 i_link.tms [*2] ##1 !i_link.tms [*2]; endsequence
    property p_rst5; s_rst |=> o_tdo_oe_n; endproperty
    property p_float; s_rst |-> ##[1:20] !o_float_outputs; endproperty
    property p_shdr; s_shdr |=> !o_tdo_oe_n && o_tdo; endproperty
    property p_shir; s_shir ##1 !i_link.tms |-> o_tdo ##1 !o_tdo; endproperty
    property p_shir_oe; s_shir |=> !o_tdo_oe_n; endproperty
    property p_exit; !o_tdo_oe_n && i_link.tms |=> o_tdo_oe_n; endproperty
    property p_hold; !o_tdo_oe_n && !i_link.tms |=> !o_tdo_oe_n; endproperty
    // tdo must not move on the rising edge, only on the fall
    property p_fall; @(negedge i_tck) disable iff (!i_rst_n) o_tdo == tdo_at_rise; endproperty
    a_rst5: assert property (p_rst5) else $error("tdo enabled after five tms highs");
    a_float: assert property (p_float) else $error("float stays set after reset walk");
    a_shdr: assert property (p_shdr) else $error("id bit 0 not on tdo");
    a_shir: assert property (p_shir) else $error("capture-ir pattern wrong");
    a_shir_oe: assert property (p_shir_oe) else $error("tdo off in shift-ir");
    a_exit: assert property (p_exit) else $error("tdo on after leaving shift");
    a_hold: assert property (p_hold) else $error("tdo off while shifting");
    a_fall: assert property (p_fall) else $error("tdo moved on tck rise");
endmodule
bind sbtap_port sbtap_chk #(.BSR_LEN(BSR_LEN)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_pin_ring(i_pin_ring), .i_tck(i_tck), .i_link(i_link), .o_tdo(o_tdo),
    .o_tdo_oe_n(o_tdo_oe_n), .o_float_outputs(o_float_outputs));

// ---- testbench/sbtap_ctl_model.sv ----
// board scan controller: makes tck only within frames, drives tms and tdi
`timescale 1ns/10ps
module sbtap_ctl_model
    import sbtap_pkg::*;
(
    output logic              o_tck,
    output sbtap_link_in_type o_link,
    input wire logic          i_tdo,
    input wire logic          i_tdo_oe_n
);
    logic last;
    initial begin
        o_tck = 1'b0;
        o_link = '1;
        last = 1'b0;
    end
    // bits go lsb first; tdo is taken at each rise; when released, the last bit taken is inverted
    task automatic scan(input int n, input logic [127:0] tms, tdi, output logic [127:0] tdo);
        tdo = '0;
        for (int k = 0; k < n; k++) begin
            o_link.tms = tms[k];
            o_link.tdi = tdi[k];
            #15 o_tck = 1'b1;
            tdo[k] = i_tdo_oe_n ? ~last : i_tdo;
            last = tdo[k];
            #15 o_tck = 1'b0;
        end
        o_link = '1; // pulled-up lines once released
    endtask
endmodule

// ---- testbench/tb.sv ----
// scenario testbench for the boundary-scan test port
`timescale 1ns/10ps
module tb;
    import sbtap_pkg::*;
    localparam logic [31:0] ID = {4'h0, 5'h07, 5'h03, 6'h00, 11'h2aa, 1'h1};
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_tck;
    logic [69:0] i_pin_ring = '0;
    sbtap_link_in_type i_link;
    logic o_tdo, o_tdo_oe_n, o_float_outputs;
    logic [127:0] r;
    int n_fail = 0, total_checks = 0, cycles = 0;
    always #50 i_clk = ~i_clk;
    sbtap_port i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_pin_ring(i_pin_ring),
        .i_tck(i_tck), .i_link(i_link), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n),
        .o_float_outputs(o_float_outputs));
    sbtap_ctl_model i_ctl (.o_tck(i_tck), .o_link(i_link), .i_tdo(o_tdo),
        .i_tdo_oe_n(o_tdo_oe_n));
    task automatic chk(input logic [127:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic go_reset(); i_ctl.scan(6, 128'h1f, '1, r); endtask
    task automatic ir_load(input logic [2:0] op);
        // tms 1,1,0,0,0,0,1,1,0: three shift rises, update-ir, back to idle
        i_ctl.scan(9, 128'h0c3, {op, 4'h0}, r);
        chk(r[5:4], 2'b01, "ir capture");
    endtask
    // enter shift-dr from idle, shift n bits, update, back to idle
    task automatic dr_scan(input int n, input logic [127:0] din);
        i_ctl.scan(n + 5, 128'h1 | (128'h3 << (n + 2)), din << 3, r);
        r = r >> 3;
    endtask
    task automatic t_id();
        go_reset();
        dr_scan(32, '0);
        chk(r[31:0], ID, "id word");
        $display("test id done");
    endtask
    task automatic t_ring(input logic [2:0] op);
        @(negedge i_clk) i_pin_ring = 70'h2a_5c3f_0f1e_9876_4321 ^ op;
        ir_load(op);
        repeat (10) @(negedge i_clk);
        chk(o_float_outputs, op != 3'h4, "float");
        dr_scan(100, 30'h2bad_c0de);
        chk(r[99:0], {30'h2bad_c0de, i_pin_ring}, "ring");
        repeat (10) @(negedge i_clk);
        chk(o_float_outputs, op != 3'h4, "float after update");
        $display("test ring %0d done", op);
    endtask
    task automatic t_byp();
        go_reset();
        ir_load(3'h7);
        dr_scan(8, 8'ha5);
        chk(r[7:0], 8'h4a, "bypass");
        $display("test bypass done");
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        go_reset();
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_id();
        t_ring(3'h4);
        t_ring(3'h0);
        t_ring(3'h2);
        t_byp();
        t_id();
        end_of_test();
    end
endmodule
